//--- hdl/dr_defs.vh
// Constants for the delayed-read prefetch engine.
// Functional notes
// - Prefetch total from max count, line size, boundary
// - Flow-through keeps prefetching until a stop condition
// - Prefetch total never below sixteen dwords
// - Max count below line size: first line boundary
// - Spare buffer space allows prefetching past total; code stops at total unless in flow-through
// - Captured enables first phase, then all zero
// - Line and multiple reads, prefetchable memory: prefetch
// - Other reads fetch one dword, forward enables
// - Stop at boundary, disconnect last, discard rest
// - Flow-through runs to 4 KB or initiator stop
// - Read and line read stop at boundary
// - Multiple read: second line boundary or full
// - Capture address, command, parity, enables; then retry
// - Issue head read after posted writes drain
// - Retry target until data; then no further attempts
// - Retry limit gives abort, removal, system error
// - Accept one dword per clock, no wait states
// - Alias memory reads; disconnect last; drop leftovers
// - Early draining enters flow-through, stalls, forwards stop
// - Discard timer drops unclaimed completions, flags error
// - Three queued reads, no duplicate enqueue
`ifndef DR_DEFS_VH
`define DR_DEFS_VH

`define CFG_LSZ_OFF     8'h0C
`define CFG_MRC_OFF     8'h48
`define LSZ_RESET       8'h00
`define MRC_RESET       32'h0000_0000
`define PFC_LSB         0
`define PFC_MSB         7

`define CMD_IO_READ     4'h2
`define CMD_MEM_READ    4'h6
`define CMD_CFG_READ    4'hA
`define CMD_MEM_MULT    4'hC
`define CMD_MEM_LINE    4'hE

`define ST_PEND         2'h0
`define ST_DONE         2'h1
`define ST_ABORT        2'h2

`define MIN_PREFETCH    11'h010
`define ALIGN16_DW      11'h010
`define DW_PER_4K       11'h400

`define RETRY_LIMIT     25'h100_0000
`define DISCARD_LONG    16'h8000
`define DISCARD_SHORT   16'h0400

`endif

//--- hdl/read_data_ram.v
// Read data buffer memory with a registered read port.
`timescale 1ns/10ps
module read_data_ram #(
	parameter WIDTH = 32,
	parameter AW    = 6
)(
	input  wire             clock,
	input  wire             wr_en,
	input  wire [AW-1:0]    wr_addr,
	input  wire [WIDTH-1:0] wr_data,
	input  wire [AW-1:0]    rd_addr,
	output reg  [WIDTH-1:0] rd_data
);

	reg [WIDTH-1:0] mem [0:(1<<AW)-1];

	// A read of the word written at the same edge returns the old word.
	always @(posedge clock)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data <= mem[rd_addr];
	end

endmodule // read_data_ram

//--- hdl/prefetch_calc.v
// Prefetch count and stop-point arithmetic for the queue head.
`timescale 1ns/10ps
`include "dr_defs.vh"
module prefetch_calc #(
	parameter BUF_AW = 6
)(
	input  wire [7:0]  cache_line_size,
	input  wire [7:0]  max_prefetch_count,
	input  wire [9:0]  addr_dw,
	input  wire [3:0]  cmd,
	input  wire        prefetchable,
	input  wire        flow_through,
	output wire [10:0] prefetch_dword_total,
	output reg  [10:0] stop_count
);

	wire        pow2;
	wire [7:0]  line_off;
	wire [10:0] to_line;
	wire [10:0] to_16;
	wire [10:0] line_boundary_count;
	wire [10:0] to_4k;
	wire [10:0] over;
	wire [10:0] raw_total;
	wire [10:0] buf_dw;
	reg  [10:0] limit;

	// Line sizes that are not a small power of two fall back to 16 dwords.
	assign pow2 = (cache_line_size == 8'h01) | (cache_line_size == 8'h02) |
		(cache_line_size == 8'h04) | (cache_line_size == 8'h08) |
		(cache_line_size == 8'h10) | (cache_line_size == 8'h20) |
		(cache_line_size == 8'h40);
	assign line_off = addr_dw[7:0] & (cache_line_size - 8'h01);
	assign to_line  = {3'b000, cache_line_size} - {3'b000, line_off};
	assign to_16    = `ALIGN16_DW - {7'h00, addr_dw[3:0]};
	assign line_boundary_count = pow2 ? to_line : to_16;
	assign to_4k    = `DW_PER_4K - {1'b0, addr_dw};
	assign buf_dw   = 11'h001 << BUF_AW;

	// Below one line of count only the first line boundary counts.
	assign over = (max_prefetch_count < cache_line_size) ? 11'h000 :
		({3'b000, max_prefetch_count} - {3'b000, cache_line_size});
	assign raw_total = over + line_boundary_count;
	assign prefetch_dword_total = (raw_total < `MIN_PREFETCH) ?
		`MIN_PREFETCH : raw_total;

	// Boundary limit by command; flow-through may pass the total.
	always @*
	begin
		if (!prefetchable)
			limit = 11'h001;
		else if (flow_through)
			limit = to_4k;
		else if (cmd == `CMD_MEM_MULT)
			limit = pow2 ? (to_line + {3'b000, cache_line_size}) :
				buf_dw;
		else
			limit = line_boundary_count;
		if (!flow_through && prefetchable && limit > prefetch_dword_total)
			limit = prefetch_dword_total;
		stop_count = (limit > to_4k) ? to_4k : limit;
	end

endmodule // prefetch_calc

//--- hdl/delayed_read_prefetch_engine.v
// Delayed-read queue, target-bus fetch and initiator-bus delivery.
`timescale 1ns/10ps
`include "dr_defs.vh"
module delayed_read_prefetch_engine #(
	parameter        Q_DEPTH       = 3,
	parameter        BUF_AW        = 6,
	parameter [24:0] RETRY_LIMIT   = `RETRY_LIMIT,
	parameter [15:0] DISCARD_LONG  = `DISCARD_LONG,
	parameter [15:0] DISCARD_SHORT = `DISCARD_SHORT
)(
	input  wire        clock,
	input  wire        rst,
	input  wire        cfg_wr,
	input  wire        cfg_rd,
	input  wire [7:0]  cfg_addr,
	input  wire [31:0] cfg_wdata,
	input  wire [3:0]  cfg_be,
	output reg  [31:0] cfg_rdata,
	input  wire        serr_enable,
	input  wire        master_timeout_short,
	input  wire        posted_writes_clear,
	input  wire        ini_start,
	input  wire [31:0] ini_addr,
	input  wire [3:0]  ini_cmd,
	input  wire        ini_par,
	input  wire        ini_pref_region,
	input  wire        ini_irdy,
	input  wire        ini_frame,
	input  wire [3:0]  ini_be_n,
	output reg         ini_trdy,
	output reg         ini_stop,
	output reg         ini_abort,
	output wire [31:0] ini_data,
	output reg         tgt_req,
	output reg  [31:0] tgt_addr,
	output reg  [3:0]  tgt_cmd,
	output reg         tgt_par,
	output reg  [3:0]  tgt_be_n,
	output reg         tgt_frame,
	input  wire        tgt_trdy,
	input  wire        tgt_stop,
	input  wire        tgt_abort,
	input  wire [31:0] tgt_data,
	output reg         primary_system_error_out
);

	localparam I_IDLE = 2'b00;
	localparam I_BE   = 2'b01;
	localparam I_XFER = 2'b10;
	localparam I_END  = 2'b11;
	localparam T_IDLE = 1'b0;
	localparam T_DATA = 1'b1;

	// Memory read, line and multiple compare as one command.
	function [3:0] read_alias;
		input [3:0] c;
		begin
			if (c == `CMD_MEM_LINE || c == `CMD_MEM_MULT)
				read_alias = `CMD_MEM_READ;
			else
				read_alias = c;
		end
	endfunction

	function same_req;
		input [29:0] a0;
		input [3:0]  c0;
		input [29:0] a1;
		input [3:0]  c1;
		begin
			same_req = (a0 == a1) && (read_alias(c0) == read_alias(c1));
		end
	endfunction

	function is_pref;
		input [3:0] c;
		input       region;
		begin
			is_pref = (c == `CMD_MEM_LINE) || (c == `CMD_MEM_MULT) ||
				((c == `CMD_MEM_READ) && region);
		end
	endfunction

	reg  [7:0]  cache_line_size_cfg_r;
	reg  [31:0] memory_read_control_r;
	reg         q_v     [0:Q_DEPTH-1];
	reg  [29:0] q_addr  [0:Q_DEPTH-1];
	reg  [3:0]  q_cmd   [0:Q_DEPTH-1];
	reg  [3:0]  q_be_n  [0:Q_DEPTH-1];
	reg         q_pf    [0:Q_DEPTH-1];
	reg         q_par   [0:Q_DEPTH-1];
	reg  [1:0]  q_st    [0:Q_DEPTH-1];
	reg  [1:0]  ist_r;
	reg         tst_r;
	reg  [29:0] cap_addr_r;
	reg  [3:0]  cap_cmd_r;
	reg         cap_par_r;
	reg         cap_region_r;
	reg         flow_r;
	reg         cancel_r;
	reg  [10:0] rd_cnt_r;
	reg  [10:0] wr_cnt_r;
	reg  [24:0] retry_cnt_r;
	reg  [15:0] disc_cnt_r;
	reg         any_hit;
	integer     tail;
	integer     i, j, k;
	wire [10:0] stop_cnt;
	wire [10:0] buf_dw;

	assign buf_dw = 11'h001 << BUF_AW;

	// Duplicate search and first free slot over the whole queue.
	always @*
	begin
		any_hit = 1'b0;
		tail = 0;
		for (k = Q_DEPTH - 1; k >= 0; k = k - 1)
		begin
			if (!q_v[k])
				tail = k;
			if (q_v[k] && same_req(q_addr[k], q_cmd[k], cap_addr_r, cap_cmd_r))
				any_hit = 1'b1;
		end
	end

	// Decisions taken when the repeated or new read shows its enables.
	wire decide   = (ist_r == I_BE) && ini_irdy;
	wire head_hit = q_v[0] &&
		same_req(q_addr[0], q_cmd[0], cap_addr_r, cap_cmd_r);
	wire fetching = (tst_r == T_DATA) && !cancel_r;
	wire go_abort = decide && head_hit && (q_st[0] == `ST_ABORT);
	wire go_xfer  = decide && head_hit && ((q_st[0] == `ST_DONE) ||
		(q_pf[0] && fetching));
	wire q_push   = decide && !any_hit && !q_v[Q_DEPTH-1];

	// Delivery arithmetic; data counts only once it sits in memory.
	wire        in_xfer = (ist_r == I_XFER);
	wire        xfer    = in_xfer && ini_trdy && ini_irdy;
	wire [10:0] rd_n    = rd_cnt_r + {10'h000, xfer};
	wire [10:0] rd_n1   = rd_n + 11'h001;
	wire        more    = (rd_n < wr_cnt_r);
	wire        fin     = (q_st[0] == `ST_DONE);
	wire        err     = (q_st[0] == `ST_ABORT);
	wire        stop_nxt = (fin && (rd_n1 >= wr_cnt_r)) || err;
	wire        end_x   = in_xfer && ((ini_stop && (!ini_trdy || ini_irdy)) ||
		(xfer && !ini_frame));

	// Discard timer runs only while a finished read waits unclaimed.
	wire disc_run = q_v[0] && (q_st[0] == `ST_DONE) && (ist_r == I_IDLE);
	wire disc_exp = disc_run && (disc_cnt_r == 16'h0001);
	wire q_pop    = end_x || go_abort || disc_exp;

	// Target-bus fetch conditions.
	wire        start_t = (tst_r == T_IDLE) && q_v[0] &&
		(q_st[0] == `ST_PEND) && posted_writes_clear && !q_pop;
	wire        wr_en   = (tst_r == T_DATA) && tgt_trdy && !cancel_r;
	wire [10:0] wr_n    = wr_cnt_r + 11'h001;
	wire [10:0] occ_n   = wr_n - rd_n;
	wire        keep    = ((wr_n + 11'h001) < stop_cnt) &&
		((occ_n + 11'h001) < buf_dw) && !cancel_r && !q_pop;
	wire        ended   = tgt_trdy ? (!tgt_frame || tgt_stop) : tgt_stop;
	wire        retried = tgt_stop && !tgt_trdy && (wr_cnt_r == 11'h000);
	wire        live    = (tst_r == T_DATA) && !cancel_r;
	wire        exhausted = live && retried &&
		(retry_cnt_r == (RETRY_LIMIT - 25'h000_0001));
	wire        h_abort = live && (tgt_abort || exhausted);
	wire        h_done  = live && !tgt_abort && ended && !retried;

	prefetch_calc #(
		.BUF_AW (BUF_AW)
	) u_calc (
		.cache_line_size      (cache_line_size_cfg_r),
		.max_prefetch_count   (memory_read_control_r[`PFC_MSB:`PFC_LSB]),
		.addr_dw              (q_addr[0][9:0]),
		.cmd                  (q_cmd[0]),
		.prefetchable         (q_pf[0]),
		.flow_through         (flow_r),
		.prefetch_dword_total (),
		.stop_count           (stop_cnt)
	);

	read_data_ram #(
		.WIDTH (32),
		.AW    (BUF_AW)
	) u_ram (
		.clock   (clock),
		.wr_en   (wr_en),
		.wr_addr (wr_cnt_r[BUF_AW-1:0]),
		.wr_data (tgt_data),
		.rd_addr (rd_n[BUF_AW-1:0]),
		.rd_data (ini_data)
	);

	// Configuration space access to line size and read control.
	always @(posedge clock)
	begin
		if (rst)
		begin
			cache_line_size_cfg_r <= `LSZ_RESET;
			memory_read_control_r <= `MRC_RESET;
			cfg_rdata             <= 32'h0000_0000;
		end
		else
		begin
			if (cfg_wr)
			begin
				if (cfg_addr == `CFG_LSZ_OFF)
				begin
					if (cfg_be[0])
						cache_line_size_cfg_r <= cfg_wdata[7:0];
				end
				else if (cfg_addr == `CFG_MRC_OFF)
				begin
					for (j = 0; j < 4; j = j + 1)
						if (cfg_be[j])
							memory_read_control_r[j*8 +: 8] <= cfg_wdata[j*8 +: 8];
				end
			end
			if (cfg_rd)
			begin
				if (cfg_addr == `CFG_LSZ_OFF)
					cfg_rdata <= {24'h00_0000, cache_line_size_cfg_r};
				else if (cfg_addr == `CFG_MRC_OFF)
					cfg_rdata <= memory_read_control_r;
				else
					cfg_rdata <= 32'h0000_0000;
			end
		end
	end

	// Request queue; the head is always slot zero and pops shift down.
	always @(posedge clock)
	begin
		if (rst)
		begin
			for (i = 0; i < Q_DEPTH; i = i + 1)
				q_v[i] <= 1'b0;
		end
		else if (q_pop)
		begin
			for (i = 0; i < Q_DEPTH - 1; i = i + 1)
			begin
				q_v[i]    <= q_v[i+1];
				q_addr[i] <= q_addr[i+1];
				q_cmd[i]  <= q_cmd[i+1];
				q_be_n[i] <= q_be_n[i+1];
				q_pf[i]   <= q_pf[i+1];
				q_par[i]  <= q_par[i+1];
				q_st[i]   <= q_st[i+1];
			end
			q_v[Q_DEPTH-1] <= 1'b0;
		end
		else
		begin
			if (h_abort)
				q_st[0] <= `ST_ABORT;
			else if (h_done)
				q_st[0] <= `ST_DONE;
			if (q_push)
			begin
				q_v[tail]    <= 1'b1;
				q_addr[tail] <= cap_addr_r;
				q_cmd[tail]  <= cap_cmd_r;
				q_be_n[tail] <= ini_be_n;
				q_pf[tail]   <= is_pref(cap_cmd_r, cap_region_r);
				q_par[tail]  <= cap_par_r;
				q_st[tail]   <= `ST_PEND;
			end
		end
	end

	// Initiator-bus side: capture, retry, abort and data delivery.
	always @(posedge clock)
	begin
		if (rst)
		begin
			ist_r        <= I_IDLE;
			ini_trdy     <= 1'b0;
			ini_stop     <= 1'b0;
			ini_abort    <= 1'b0;
			cap_addr_r   <= 30'h0000_0000;
			cap_cmd_r    <= 4'h0;
			cap_par_r    <= 1'b0;
			cap_region_r <= 1'b0;
		end
		else
		begin
			case (ist_r)
			I_IDLE:
			begin
				ini_trdy  <= 1'b0;
				ini_stop  <= 1'b0;
				ini_abort <= 1'b0;
				if (ini_start)
				begin
					cap_addr_r   <= ini_addr[31:2];
					cap_cmd_r    <= ini_cmd;
					cap_par_r    <= ini_par;
					cap_region_r <= ini_pref_region;
					ist_r        <= I_BE;
				end
			end
			I_BE:
			begin
				if (ini_irdy)
				begin
					if (go_abort)
					begin
						ini_abort <= 1'b1;
						ini_stop  <= 1'b1;
						ist_r     <= I_END;
					end
					else if (go_xfer)
					begin
						ini_trdy <= more;
						ini_stop <= stop_nxt;
						ist_r    <= I_XFER;
					end
					else
					begin
						ini_stop <= 1'b1;
						ist_r    <= I_END;
					end
				end
			end
			I_XFER:
			begin
				if (end_x)
				begin
					ini_trdy <= 1'b0;
					ini_stop <= 1'b0;
					ist_r    <= I_IDLE;
				end
				else
				begin
					ini_trdy <= more;
					ini_stop <= stop_nxt;
				end
			end
			default:
			begin
				ini_trdy  <= 1'b0;
				ini_stop  <= 1'b0;
				ini_abort <= 1'b0;
				ist_r     <= I_IDLE;
			end
			endcase
		end
	end

	// Buffer counters; a pop throws away whatever is left undelivered.
	always @(posedge clock)
	begin
		if (rst || q_pop)
		begin
			rd_cnt_r <= 11'h000;
			wr_cnt_r <= 11'h000;
			flow_r   <= 1'b0;
		end
		else
		begin
			rd_cnt_r <= rd_n;
			if (wr_en)
				wr_cnt_r <= wr_n;
			if (xfer && fetching)
				flow_r <= 1'b1;
		end
	end

	// Target-bus master: issue, count retries, stream data into memory.
	always @(posedge clock)
	begin
		if (rst)
		begin
			tst_r       <= T_IDLE;
			tgt_req     <= 1'b0;
			tgt_addr    <= 32'h0000_0000;
			tgt_cmd     <= 4'h0;
			tgt_par     <= 1'b0;
			tgt_be_n    <= 4'hF;
			tgt_frame   <= 1'b0;
			retry_cnt_r <= 25'h000_0000;
			cancel_r    <= 1'b0;
		end
		else
		begin
			case (tst_r)
			T_IDLE:
			begin
				cancel_r <= 1'b0;
				if (start_t)
				begin
					tgt_req   <= 1'b1;
					tgt_addr  <= {q_addr[0], 2'b00};
					tgt_cmd   <= q_cmd[0];
					tgt_par   <= q_par[0];
					tgt_be_n  <= q_be_n[0];
					tgt_frame <= (stop_cnt > 11'h001);
					tst_r     <= T_DATA;
				end
			end
			default:
			begin
				tgt_req <= 1'b0;
				if (q_pop)
					cancel_r <= 1'b1;
				if (retried && !cancel_r)
					retry_cnt_r <= exhausted ? 25'h000_0000 :
						retry_cnt_r + 25'h000_0001;
				else if (h_done)
					retry_cnt_r <= 25'h000_0000;
				if (tgt_abort || ended)
				begin
					tst_r     <= T_IDLE;
					tgt_frame <= 1'b0;
					tgt_be_n  <= 4'hF;
				end
				else if (tgt_trdy)
				begin
					tgt_be_n  <= 4'h0;
					tgt_frame <= keep;
				end
				else
					tgt_frame <= tgt_frame && !cancel_r && !q_pop;
			end
			endcase
		end
	end

	// Discard timer reload value follows the master timeout choice.
	always @(posedge clock)
	begin
		if (rst || !disc_run || q_pop)
			disc_cnt_r <= master_timeout_short ? DISCARD_SHORT : DISCARD_LONG;
		else if (disc_cnt_r != 16'h0000)
			disc_cnt_r <= disc_cnt_r - 16'h0001;
	end

	// System error is a one-cycle pulse, gated by its enable.
	always @(posedge clock)
	begin
		if (rst)
			primary_system_error_out <= 1'b0;
		else
			primary_system_error_out <= serr_enable &&
				(exhausted || disc_exp);
	end

endmodule // delayed_read_prefetch_engine

//--- bench/dr_engine_props.sv
// Port-level checks for the delayed-read prefetch engine.
`timescale 1ns/10ps
module dr_engine_props (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        cfg_rd,
	input wire logic [7:0]  cfg_addr,
	input wire logic [31:0] cfg_rdata,
	input wire logic        serr_enable,
	input wire logic        posted_writes_clear,
	input wire logic        ini_start,
	input wire logic        ini_irdy,
	input wire logic        ini_trdy,
	input wire logic        ini_stop,
	input wire logic        ini_abort,
	input wire logic        tgt_req,
	input wire logic [31:0] tgt_addr,
	input wire logic [3:0]  tgt_cmd,
	input wire logic [3:0]  tgt_be_n,
	input wire logic        tgt_frame,
	input wire logic        tgt_trdy,
	input wire logic        tgt_stop,
	input wire logic        tgt_abort,
	input wire logic        primary_system_error_out
);
	default clocking dc @(posedge clock); endclocking
	default disable iff (rst);

	// A new initiator request: address phase, then ready.
	sequence new_req_s;
		ini_start ##1 ini_irdy;
	endsequence

	// The final data phase of a target-bus fetch is accepted.
	sequence last_beat_s;
		tgt_trdy && !tgt_frame && !tgt_req;
	endsequence

	answer_bound_a:
		assert property (new_req_s |-> ##[1:40] (ini_stop || ini_trdy))
		else $error("initiator got no answer");
	retry_single_a:
		assert property ((ini_stop && !ini_trdy) |=> !ini_stop)
		else $error("retry lasted more than one cycle");
	abort_stop_a:
		assert property (ini_abort |-> ini_stop ##1 !ini_abort)
		else $error("abort malformed");
	req_pulse_a:
		assert property (tgt_req |-> $past(posted_writes_clear) ##1 !tgt_req)
		else $error("target request malformed");
	addr_held_a:
		assert property ((tgt_frame && !tgt_req) |->
			$stable(tgt_addr) && $stable(tgt_cmd))
		else $error("target address moved");
	later_be_zero_a:
		assert property ((tgt_trdy && tgt_frame && !tgt_stop && !tgt_abort)
			|=> tgt_be_n == 4'h0)
		else $error("later enables not all on");
	no_reissue_a:
		assert property (last_beat_s |=> !tgt_req && tgt_be_n == 4'hF)
		else $error("read reissued after data");
	serr_gate_a:
		assert property (primary_system_error_out |->
			$past(serr_enable) ##1 !primary_system_error_out)
		else $error("system error pulse malformed");
	cfg_unmapped_a:
		assert property ((cfg_rd && cfg_addr != 8'h0C && cfg_addr != 8'h48)
			|=> cfg_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
endmodule // dr_engine_props

bind delayed_read_prefetch_engine dr_engine_props u_props (
	.clock(clock), .rst(rst), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
	.cfg_rdata(cfg_rdata), .serr_enable(serr_enable),
	.posted_writes_clear(posted_writes_clear), .ini_start(ini_start),
	.ini_irdy(ini_irdy), .ini_trdy(ini_trdy), .ini_stop(ini_stop),
	.ini_abort(ini_abort), .tgt_req(tgt_req), .tgt_addr(tgt_addr),
	.tgt_cmd(tgt_cmd), .tgt_be_n(tgt_be_n), .tgt_frame(tgt_frame),
	.tgt_trdy(tgt_trdy), .tgt_stop(tgt_stop), .tgt_abort(tgt_abort),
	.primary_system_error_out(primary_system_error_out)
);

//--- bench/target_model.sv
// Behavioural far-bus target: retries a request, then streams dwords.
`timescale 1ns/10ps
module target_model (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        tgt_req,
	input  wire logic        tgt_frame,
	input  wire logic [31:0] tgt_addr,
	input  wire logic [3:0]  tgt_be_n,
	input  wire logic [7:0]  retries,
	output logic             tgt_trdy,
	output logic             tgt_stop,
	output logic             tgt_abort,
	output logic      [31:0] tgt_data,
	output logic      [3:0]  first_be,
	output int               beats,
	output int               dones,
	output int               reqs
);
	logic [7:0]  tries_r;
	logic [31:0] nxt_a;

	// Address of the dword that follows the one now on the bus.
	assign nxt_a = tgt_addr + 32'((beats + 1) * 4);

	// Off-beat the bus shows the inverse, so stale data never matches.
	always @(posedge clock)
	begin
		tgt_stop <= 1'b0;
		tgt_abort <= 1'b0;
		tgt_data <= ~tgt_data;
		if (rst)
		begin
			tgt_trdy <= 1'b0;
			tries_r <= 8'h00;
			{beats, dones, reqs} <= '0;
		end
		else if (tgt_req)
		begin
			reqs <= reqs + 1;
			first_be <= tgt_be_n;
			beats <= 0;
			if (tries_r < retries)
			begin
				tries_r <= tries_r + 8'h01;
				tgt_stop <= 1'b1;
			end
			else
			begin
				tgt_trdy <= 1'b1;
				tgt_data <= {tgt_addr[15:0], ~tgt_addr[15:0]};
			end
		end
		else if (tgt_trdy)
		begin
			beats <= beats + 1;
			if (!tgt_frame)
			begin
				tgt_trdy <= 1'b0;
				tries_r <= 8'h00;
				dones <= dones + 1;
			end
			else
				tgt_data <= {nxt_a[15:0], ~nxt_a[15:0]};
		end
	end
endmodule // target_model

//--- bench/delayed_read_prefetch_engine_tb.sv
// Self-checking bench for the delayed-read prefetch engine.
`timescale 1ns/10ps
`include "dr_defs.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module delayed_read_prefetch_engine_tb;
	logic clock, rst, cfg_wr, cfg_rd, serr_enable, master_timeout_short;
	logic posted_writes_clear, ini_start, ini_par, ini_pref_region;
	logic ini_irdy, ini_frame, ini_trdy, ini_stop, ini_abort, tgt_req;
	logic tgt_par, tgt_frame, tgt_trdy, tgt_stop, tgt_abort, serr_out;
	logic [7:0]  cfg_addr, retries;
	logic [31:0] cfg_wdata, cfg_rdata, ini_addr, ini_data, tgt_addr;
	logic [31:0] tgt_data, q, a;
	logic [3:0]  cfg_be, ini_cmd, ini_be_n, tgt_cmd, tgt_be_n, first_be, c;
	int errors = 0, samples_checked = 0, serr_cnt = 0;
	int beats, dones, reqs, i, res, n, d0, r0, s0, lsz;
	int sizes[7] = '{1, 2, 4, 8, 16, 3, 12};
	logic [3:0] cmds[5] = '{`CMD_IO_READ, `CMD_CFG_READ, `CMD_MEM_READ,
		`CMD_MEM_LINE, `CMD_MEM_MULT};

	delayed_read_prefetch_engine #(.RETRY_LIMIT(25'h000_0004),
		.DISCARD_LONG(16'h0014), .DISCARD_SHORT(16'h000A)) u_dut (
		.clock(clock), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be),
		.cfg_rdata(cfg_rdata), .serr_enable(serr_enable),
		.master_timeout_short(master_timeout_short),
		.posted_writes_clear(posted_writes_clear), .ini_start(ini_start),
		.ini_addr(ini_addr), .ini_cmd(ini_cmd), .ini_par(ini_par),
		.ini_pref_region(ini_pref_region), .ini_irdy(ini_irdy),
		.ini_frame(ini_frame), .ini_be_n(ini_be_n), .ini_trdy(ini_trdy),
		.ini_stop(ini_stop), .ini_abort(ini_abort), .ini_data(ini_data),
		.tgt_req(tgt_req), .tgt_addr(tgt_addr), .tgt_cmd(tgt_cmd),
		.tgt_par(tgt_par), .tgt_be_n(tgt_be_n), .tgt_frame(tgt_frame),
		.tgt_trdy(tgt_trdy), .tgt_stop(tgt_stop), .tgt_abort(tgt_abort),
		.tgt_data(tgt_data), .primary_system_error_out(serr_out));

	target_model u_target (.clock(clock), .rst(rst), .tgt_req(tgt_req),
		.tgt_frame(tgt_frame), .tgt_addr(tgt_addr), .tgt_be_n(tgt_be_n),
		.retries(retries), .tgt_trdy(tgt_trdy), .tgt_stop(tgt_stop),
		.tgt_abort(tgt_abort), .tgt_data(tgt_data), .first_be(first_be),
		.beats(beats), .dones(dones), .reqs(reqs));

	// Free-running 40 MHz clock.
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// System error pulses are counted as they are seen.
	always @(posedge clock)
		if (serr_out === 1'b1)
			serr_cnt++;

	task automatic stop_test;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic fail_wait;
		errors++;
		$display("BAD wait exp answer got timeout");
		stop_test;
	endtask

	function automatic logic [31:0] dwv(input logic [31:0] x);
		return {x[15:0], ~x[15:0]};
	endfunction

	// Dwords fetched; every random-loop case keeps the boundary at or below sixteen.
	function automatic int exp_n(input [3:0] k, input logic p, input int s,
		input [31:0] x);
		int w;
		w = (s inside {1, 2, 4, 8, 16, 32, 64}) ? s : 16;
		if (k == `CMD_IO_READ || k == `CMD_CFG_READ ||
			(k == `CMD_MEM_READ && !p))
			return 1;
		if (k == `CMD_MEM_MULT)
			return 2 * s - x[31:2] % s;
		return w - x[31:2] % w;
	endfunction

	task automatic cfg(input logic wr, input [7:0] ad, input [3:0] be,
		input [31:0] d);
		cfg_wr <= wr;
		cfg_rd <= !wr;
		cfg_addr <= ad;
		cfg_be <= be;
		cfg_wdata <= d;
		@(posedge clock);
		cfg_wr <= 1'b0;
		cfg_rd <= 1'b0;
		@(negedge clock);
		q = cfg_rdata;
		@(posedge clock);
	endtask

	// Waits until the fetch count or the error count moves.
	task automatic wait_change(input logic on_serr, input int v0);
		int k;
		for (k = 0; k < 400; k++)
		begin
			@(negedge clock);
			if ((on_serr ? serr_cnt : dones) != v0)
				break;
		end
		if (k == 400)
			fail_wait;
		@(posedge clock);
	endtask

	// One initiator attempt; res 0 retry, 1 abort, 2 data; early ends
	// the burst by dropping the frame before that many dwords.
	task automatic rd(input [31:0] x, input [3:0] k, input logic p,
		input [3:0] be, input int early);
		int t;
		ini_start <= 1'b1;
		ini_addr <= x;
		ini_cmd <= k;
		ini_par <= ^{x, k};
		ini_pref_region <= p;
		ini_be_n <= be;
		@(posedge clock);
		ini_start <= 1'b0;
		ini_irdy <= 1'b1;
		ini_frame <= 1'b1;
		n = 0;
		res = -1;
		for (t = 0; t < 300 && res < 0; t++)
		begin
			@(negedge clock);
			if (ini_abort === 1'b1)
				res = 1;
			else if (ini_trdy === 1'b1)
			begin
				`CHK("ini_data", dwv(x + 4 * n), ini_data)
				n++;
				if (ini_stop === 1'b1 || ini_frame === 1'b0)
					res = 2;
			end
			else if (ini_stop === 1'b1)
				res = 0;
			@(posedge clock);
			if (n == early - 1)
				ini_frame <= 1'b0;
		end
		if (res < 0)
			fail_wait;
		ini_irdy <= 1'b0;
		ini_frame <= 1'b0;
		repeat (2) @(posedge clock);
	endtask

	// Post, let the target fetch, then collect the data.
	task automatic full(input [31:0] x, input [3:0] k, input logic p,
		input [3:0] be, input int e);
		d0 = dones;
		rd(x, k, p, be, 0);
		`CHK("first answer", 0, res)
		wait_change(0, d0);
		`CHK("fetched", e, beats)
		`CHK("enables", be, first_be)
		rd(x, k, p, be, 0);
		`CHK("delivered", e, n)
	endtask

	initial
	begin
		{cfg_wr, cfg_rd, master_timeout_short, ini_start, ini_par} = '0;
		{ini_pref_region, ini_irdy, ini_frame, cfg_addr, retries} = '0;
		{cfg_wdata, ini_addr, cfg_be, ini_cmd, ini_be_n} = '0;
		{rst, serr_enable, posted_writes_clear} = 3'b111;
		void'($urandom(57626));
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		cfg(0, 8'h0C, 4'hF, 0);
		`CHK("line size reset", 32'h0000_0000, q)
		cfg(1, 8'h10, 4'hF, 32'hFFFF_FFFF);
		cfg(0, 8'h10, 4'hF, 0);
		`CHK("unmapped", 0, q)
		cfg(1, 8'h48, 4'h1, 32'hFFFF_FFFF);
		cfg(0, 8'h48, 4'hF, 0);
		`CHK("read control lane", 32'h0000_00FF, q)
		for (i = 0; i < 16; i++)
		begin
			lsz = sizes[$urandom % 7];
			c = cmds[$urandom % 5];
			if (c == `CMD_MEM_MULT && (lsz > 8 || lsz == 3))
				c = `CMD_MEM_LINE;
			a = $urandom & 32'hFFFF_FFFC;
			retries <= 8'($urandom % 3);
			cfg(1, 8'h0C, 4'h1, lsz);
			cfg(1, 8'h48, 4'hF, $urandom);
			cfg(0, 8'h0C, 4'hF, 0);
			`CHK("line size", lsz, q)
			r0 = reqs;
			s0 = $urandom % 2;
			full(a, c, s0[0], 4'($urandom), exp_n(c, s0[0], lsz, a));
			`CHK("attempts", r0 + retries + 1, reqs)
		end
		retries <= 8'h00;
		cfg(1, 8'h0C, 4'h1, 8);
		d0 = dones;
		rd(32'h0000_2040, `CMD_MEM_LINE, 0, 4'h0, 0);
		wait_change(0, d0);
		rd(32'h0000_2040, `CMD_MEM_MULT, 0, 4'h0, 3);
		`CHK("early end", 3, n)
		full(32'h0000_2040, `CMD_MEM_LINE, 0, 4'h0, 8);
		rd(32'h0000_3000, `CMD_MEM_MULT, 0, 4'h0, 0);
		rd(32'h0000_3000, `CMD_MEM_MULT, 0, 4'h0, 20);
		`CHK("flow", 20, n)
		posted_writes_clear <= 1'b0;
		r0 = reqs;
		for (i = 0; i < 5; i++)
		begin
			rd(32'h0000_0100 + 4 * (i - (i > 0)), `CMD_IO_READ, 0, 4'h3, 0);
			`CHK("queued retry", 0, res)
		end
		`CHK("held back", r0, reqs)
		d0 = dones;
		posted_writes_clear <= 1'b1;
		for (i = 0; i < 3; i++)
		begin
			wait_change(0, d0);
			d0 = dones;
			rd(32'h0000_0100 + 4 * i, `CMD_IO_READ, 0, 4'h3, 0);
			`CHK("queued data", 1, n)
		end
		`CHK("one fetch each", r0 + 3, reqs)
		`CHK("no flag yet", 0, serr_cnt)
		master_timeout_short <= 1'b1;
		d0 = dones;
		rd(32'h0000_0200, `CMD_IO_READ, 0, 4'h0, 0);
		wait_change(0, d0);
		wait_change(1, 0);
		`CHK("discard flag", 1, serr_cnt)
		full(32'h0000_0200, `CMD_IO_READ, 0, 4'h0, 1);
		retries <= 8'hFF;
		r0 = reqs;
		rd(32'h0000_0300, `CMD_MEM_READ, 1, 4'h0, 0);
		wait_change(1, 1);
		`CHK("limit flag", 2, serr_cnt)
		`CHK("limit attempts", r0 + 4, reqs)
		rd(32'h0000_0300, `CMD_MEM_READ, 1, 4'h0, 0);
		`CHK("abort", 1, res)
		retries <= 8'h00;
		full(32'h0000_0300, `CMD_MEM_READ, 1, 4'h0, 8);
		cfg(1, 8'h0C, 4'h1, 12);
		cfg(1, 8'h48, 4'h1, 0);
		full(32'h0000_4000, `CMD_MEM_MULT, 0, 4'h0, 16);
		cfg(1, 8'h48, 4'h1, 40);
		full(32'h0000_4100, `CMD_MEM_MULT, 0, 4'h0, 44);
		stop_test;
	end
endmodule // delayed_read_prefetch_engine_tb
